//--- design/das_top.sv
// debug access and scan-security block: jtag tap router, key register,
// unlock compare, debug bus frames with locator rom.
// assumes bus signals are on mclk_i; jtag pins on tck_i; otp code static.
// What this block does
// - decode two 4KB debug frames; unmapped reads zero, writes ignored
// - jtag id code equals tap router id code, a 32-bit constant
// - locator rom holds five fixed words ending in a zero marker
// - tap router enables four internal secondary taps; only tap 2's tdo returns to external jtag
// - read 128-bit visible code from otp; factory code leaves device open
// - xor otp code with key, mix hidden constants, compare hidden value
// - match asserts access-released; no match keeps it low
// - all-zero visible code keeps device secured forever
// - key register cleared only by power-on reset
// - while secured only the key chain via the router's own IR_KEY instruction, bypass and the id code loaded by tap reset work
// - while secured other taps, test taps and boundary scan blocked
// - boundary chain shifts from tdi to tdo through the router
`timescale 1ns/1ps
`default_nettype none
module das_top
    import das_pkg::*;
#(
    parameter int BSCAN_LEN = 8
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic power_on_reset_n_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic returned_test_clock_o,
    input wire logic [127:0] otp_code_i,
    input wire logic [BSCAN_LEN-1:0] bscan_pins_i,
    output logic [BSCAN_LEN-1:0] bscan_cells_o,
    output logic [3:0] sec_tap_en_o,
    input wire logic [3:0] sec_tap_tdo_i,
    input wire logic dbg_sel_i,
    input wire logic dbg_write_i,
    input wire logic [31:0] dbg_addr_i,
    input wire logic [31:0] dbg_wdata_i,
    output logic [31:0] dbg_rdata_o,
    output logic locator_rom_frame_select_o,
    output logic cpu_debug_frame_select_o,
    output logic access_released_o
);
    function automatic logic in_frame(input logic [31:0] a,
                                      input logic [31:0] base);
        in_frame = (a[31:FRAME_BITS] == base[31:FRAME_BITS]);
    endfunction

    // key register lives in the jtag domain; only power-on reset clears it
    das_tap_e st;
    das_tap_e next_st;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [31:0] dr_sh;
    logic [127:0] key_scan_register;
    logic [127:0] key_sh;
    logic key_tgl;
    logic [BSCAN_LEN-1:0] bs_sh;
    logic [3:0] tap_sel;
    logic [1:0] rel_tck_sync;
    logic released_tck;
    logic tdo_n;
    logic [1:0] tdo_mux;

    always_comb begin
        next_st = st;
        case (st)
            DAS_RESET: next_st = tms_i ? DAS_RESET : DAS_IDLE;
            DAS_IDLE: next_st = tms_i ? DAS_SEL_DR : DAS_IDLE;
            DAS_SEL_DR: next_st = tms_i ? DAS_SEL_IR : DAS_CAP_DR;
            DAS_CAP_DR: next_st = tms_i ? DAS_EX1_DR : DAS_SH_DR;
            DAS_SH_DR: next_st = tms_i ? DAS_EX1_DR : DAS_SH_DR;
            DAS_EX1_DR: next_st = tms_i ? DAS_UP_DR : DAS_PA_DR;
            DAS_PA_DR: next_st = tms_i ? DAS_EX2_DR : DAS_PA_DR;
            DAS_EX2_DR: next_st = tms_i ? DAS_UP_DR : DAS_SH_DR;
            DAS_UP_DR: next_st = tms_i ? DAS_SEL_DR : DAS_IDLE;
            DAS_SEL_IR: next_st = tms_i ? DAS_RESET : DAS_CAP_IR;
            DAS_CAP_IR: next_st = tms_i ? DAS_EX1_IR : DAS_SH_IR;
            DAS_SH_IR: next_st = tms_i ? DAS_EX1_IR : DAS_SH_IR;
            DAS_EX1_IR: next_st = tms_i ? DAS_UP_IR : DAS_PA_IR;
            DAS_PA_IR: next_st = tms_i ? DAS_EX2_IR : DAS_PA_IR;
            DAS_EX2_IR: next_st = tms_i ? DAS_UP_IR : DAS_SH_IR;
            DAS_UP_IR: next_st = tms_i ? DAS_SEL_DR : DAS_IDLE;
            default: next_st = DAS_RESET;
        endcase
    end

    always_ff @(posedge tck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= DAS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // released level crosses into the jtag domain through two flops
    always_ff @(posedge tck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rel_tck_sync <= 2'b00;
        end else begin
            rel_tck_sync <= {rel_tck_sync[0], access_released_o};
        end
    end
    assign released_tck = rel_tck_sync[1];

    always_ff @(posedge tck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ir <= IR_IDCODE;
            ir_sh <= 4'h0;
        end else if (st == DAS_RESET) begin
            ir <= IR_IDCODE;
        end else if (st == DAS_CAP_IR) begin
            ir_sh <= 4'h1;
        end else if (st == DAS_SH_IR) begin
            ir_sh <= {tdi_i, ir_sh[3:1]};
        end else if (st == DAS_UP_IR) begin
            // secured: anything but the key chain falls back to bypass
            if (released_tck || ir_sh == IR_KEY || ir_sh == IR_BYPASS) begin
                ir <= ir_sh;
            end else begin
                ir <= IR_BYPASS;
            end
        end
    end

    always_ff @(posedge tck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dr_sh <= 32'h0000_0000;
            key_sh <= KEY_RESET;
            bs_sh <= '0;
        end else if (st == DAS_CAP_DR) begin
            dr_sh <= (ir == IR_IDCODE) ? ID_CODE : 32'h0000_0000;
            bs_sh <= bscan_pins_i;
        end else if (st == DAS_SH_DR) begin
            dr_sh <= {tdi_i, dr_sh[31:1]};
            if (ir == IR_KEY) begin
                key_sh <= {tdi_i, key_sh[127:1]};
            end
            if (ir == IR_BSCAN) begin
                bs_sh <= {tdi_i, bs_sh[BSCAN_LEN-1:1]};
            end
        end
    end

    always_ff @(posedge tck_i or negedge power_on_reset_n_i) begin
        if (!power_on_reset_n_i) begin
            key_scan_register <= KEY_RESET;
            key_tgl <= 1'b0;
        end else if (st == DAS_UP_DR && ir == IR_KEY) begin
            key_scan_register <= key_sh;
            key_tgl <= ~key_tgl;
        end
    end

    always_ff @(posedge tck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tap_sel <= 4'h0;
            bscan_cells_o <= '0;
        end else if (!released_tck) begin
            tap_sel <= 4'h0;
        end else if (st == DAS_UP_DR && ir == IR_SELTAP) begin
            tap_sel <= dr_sh[31:28];
        end else if (st == DAS_UP_DR && ir == IR_BSCAN) begin
            bscan_cells_o <= bs_sh;
        end
    end

    always_comb begin
        tdo_mux = 2'b00;
        if (st == DAS_SH_IR) begin
            tdo_n = ir_sh[0];
        end else if (ir == IR_KEY) begin
            tdo_n = key_sh[0];
        end else if (ir == IR_BSCAN) begin
            tdo_n = bs_sh[0];
        end else if (ir == IR_SELTAP) begin
            tdo_mux = SEC_TAP;
            tdo_n = sec_tap_tdo_i[tdo_mux] & tap_sel[tdo_mux];
        end else begin
            tdo_n = dr_sh[0];
        end
    end

    always_ff @(negedge tck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
            returned_test_clock_o <= 1'b0;
        end else begin
            tdo_o <= tdo_n;
            tdo_oe_o <= (st == DAS_SH_DR) || (st == DAS_SH_IR);
            returned_test_clock_o <= ~returned_test_clock_o;
        end
    end

    // tck stops between frames, so a second stage here would lag a frame
    assign sec_tap_en_o = tap_sel;

    // unlock: a load toggle is synchronised and the key word is taken
    // once it has settled; two loads within one mclk cycle may be missed
    logic [2:0] key_tgl_sync;
    logic key_primed;
    logic copy_rst_n;
    logic [127:0] key_copy;
    logic [127:0] mixed;
    logic code_zero;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            key_tgl_sync <= 3'b000;
            key_primed <= 1'b0;
        end else begin
            key_tgl_sync <= {key_tgl_sync[1:0], key_tgl};
            key_primed <= 1'b1;
        end
    end
    // the copy follows a power-on clear of the key as well
    assign copy_rst_n = nrst_i & power_on_reset_n_i;
    always_ff @(posedge mclk_i or negedge copy_rst_n) begin
        if (!copy_rst_n) begin
            key_copy <= KEY_RESET;
        end else if (!key_primed || key_tgl_sync[2] != key_tgl_sync[1]) begin
            key_copy <= key_scan_register;
        end
    end
    assign mixed = (otp_code_i ^ key_copy) ^ HIDDEN_TIE;
    assign code_zero = (otp_code_i == 128'h0);
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            access_released_o <= 1'b0;
        end else begin
            // compare runs every cycle
            access_released_o <= !code_zero
                && (mixed == HIDDEN_REF);
        end
    end

    // debug bus, one-cycle read answer
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dbg_rdata_o <= 32'h0000_0000;
            locator_rom_frame_select_o <= 1'b0;
            cpu_debug_frame_select_o <= 1'b0;
        end else begin
            locator_rom_frame_select_o <= dbg_sel_i
                && in_frame(dbg_addr_i, ROM_FRAME_BASE);
            cpu_debug_frame_select_o <= dbg_sel_i
                && in_frame(dbg_addr_i, CPU_FRAME_BASE);
            dbg_rdata_o <= 32'h0000_0000;
            if (dbg_sel_i && !dbg_write_i
                && in_frame(dbg_addr_i, ROM_FRAME_BASE)) begin
                if (dbg_addr_i[11:10] == 2'b00) begin
                    case (dbg_addr_i[11:2] & 10'h3FF)
                        ROM_IDX_PTR: dbg_rdata_o <= ROM_PTR_VAL;
                        ROM_IDX_RES1: dbg_rdata_o <= ROM_RES1_VAL;
                        ROM_IDX_RES2: dbg_rdata_o <= ROM_RES2_VAL;
                        ROM_IDX_RES3: dbg_rdata_o <= ROM_RES3_VAL;
                        ROM_IDX_END: dbg_rdata_o <= ROM_END_VAL;
                        default: dbg_rdata_o <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    logic unused_ok;
    assign unused_ok = ^{dbg_wdata_i, OTP_CODE_ADDR};

    rom_ptr_a: assert property (@(posedge mclk_i)
        disable iff (!nrst_i)
        dbg_sel_i && !dbg_write_i && dbg_addr_i == ROM_FRAME_BASE
        |=> dbg_rdata_o == ROM_PTR_VAL) else $error("rom pointer wrong");
    unmapped_zero_a: assert property (@(posedge mclk_i)
        disable iff (!nrst_i)
        !(dbg_sel_i && in_frame(dbg_addr_i, ROM_FRAME_BASE))
        |=> dbg_rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    frame_sel_a: assert property (@(posedge mclk_i)
        disable iff (!nrst_i)
        dbg_sel_i && in_frame(dbg_addr_i, CPU_FRAME_BASE)
        |=> cpu_debug_frame_select_o) else $error("cpu frame missed");
    zero_code_a: assert property (@(posedge mclk_i)
        disable iff (!nrst_i)
        $past(code_zero) |-> !access_released_o) else $error("zero code open");
    unlock_follow_a: assert property (@(posedge mclk_i)
        disable iff (!nrst_i)
        (!code_zero && mixed == HIDDEN_REF) |=> access_released_o)
        else $error("match not released");
    key_hold_a: assert property (@(posedge tck_i)
        disable iff (!power_on_reset_n_i)
        !(st == DAS_UP_DR && ir == IR_KEY) |=> $stable(key_scan_register))
        else $error("key changed");
    lock_taps_a: assert property (@(posedge tck_i)
        disable iff (!nrst_i)
        !released_tck |=> tap_sel == 4'h0) else $error("tap open secured");
    lock_ir_a: assert property (@(posedge tck_i)
        disable iff (!nrst_i)
        st == DAS_UP_IR && !released_tck && ir_sh == IR_BSCAN
        |=> ir == IR_BYPASS) else $error("bscan when secured");
    sequence key_news_s;
        key_tgl_sync[2] != key_tgl_sync[1];
    endsequence
    key_take_a: assert property (@(posedge mclk_i)
        disable iff (!copy_rst_n)
        key_news_s |=> key_copy == $past(key_scan_register))
        else $error("key copy stale");
endmodule
`default_nettype wire

//--- include/das_pkg.sv
// package for the debug access and scan-security block
// assumes one system clock, one jtag test clock and a power-on reset
package das_pkg;
    localparam logic [31:0] ROM_FRAME_BASE = 32'hFFA0_0000;
    localparam logic [31:0] CPU_FRAME_BASE = 32'hFFA0_1000;
    localparam int FRAME_BITS = 12;
    localparam logic [9:0] ROM_IDX_PTR = 10'h000;
    localparam logic [9:0] ROM_IDX_RES1 = 10'h001;
    localparam logic [9:0] ROM_IDX_RES2 = 10'h002;
    localparam logic [9:0] ROM_IDX_RES3 = 10'h003;
    localparam logic [9:0] ROM_IDX_END = 10'h004;
    localparam logic [31:0] ROM_PTR_VAL = 32'h0000_1003;
    localparam logic [31:0] ROM_RES1_VAL = 32'h0000_2002;
    localparam logic [31:0] ROM_RES2_VAL = 32'h0000_3002;
    localparam logic [31:0] ROM_RES3_VAL = 32'h0000_4002;
    localparam logic [31:0] ROM_END_VAL = 32'h0000_0000;
    localparam logic [31:0] OTP_CODE_ADDR = 32'hF000_0000;
    // arbitrary identification value, not any real part's
    localparam logic [31:0] ID_CODE = 32'h0000_1001;
    // hidden constants, arbitrary here
    localparam logic [127:0] HIDDEN_TIE =
        128'h5A5A_0F0F_3C3C_A5A5_1234_5678_9ABC_DEF0;
    localparam logic [127:0] FACTORY_CODE = {128{1'b1}};
    localparam logic [127:0] HIDDEN_REF = FACTORY_CODE ^ HIDDEN_TIE;
    localparam logic [127:0] KEY_RESET = 128'h0;
    localparam logic [1:0] SEC_TAP = 2'd2;
    localparam int IR_LEN = 4;
    localparam logic [3:0] IR_IDCODE = 4'h1;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_KEY = 4'h2;
    localparam logic [3:0] IR_BSCAN = 4'h3;
    localparam logic [3:0] IR_SELTAP = 4'h4;
    typedef enum logic [3:0] {
        DAS_RESET = 4'b0000, DAS_IDLE = 4'b0001, DAS_SEL_DR = 4'b0010,
        DAS_CAP_DR = 4'b0011, DAS_SH_DR = 4'b0100, DAS_EX1_DR = 4'b0101,
        DAS_PA_DR = 4'b0110, DAS_EX2_DR = 4'b0111, DAS_UP_DR = 4'b1000,
        DAS_SEL_IR = 4'b1001, DAS_CAP_IR = 4'b1010, DAS_SH_IR = 4'b1011,
        DAS_EX1_IR = 4'b1100, DAS_PA_IR = 4'b1101, DAS_EX2_IR = 4'b1110,
        DAS_UP_IR = 4'b1111
    } das_tap_e;
endpackage

//--- verif/das_jtag_host.sv
// jtag debugger model for the debug access block
// assumes the block samples tms/tdi on rising tck and drives tdo on falling
`timescale 1ns/1ps
`default_nettype none
module das_jtag_host (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    // tck stands still between frames, as a real probe would leave it
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // one 15 ns tck period; tdo is taken just before the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #7.5;
        tdo = tdo_i;
        tck_o = 1'b1;
        #7.5;
        tck_o = 1'b0;
    endtask

    task automatic to_idle();
        logic t;
        for (int i = 0; i < 5; i++) step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        tdi_o = 1'b1;
    endtask

    // idle to idle; ir picks the instruction path; bits go lsb first
    task automatic scan(input logic ir, input logic [127:0] din,
                        input int n, output logic [127:0] dout);
        logic t;
        dout = '0;
        step(1'b1, 1'b0, t);
        if (ir) step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], t);
            dout[i] = t;
        end
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        // released data line shows the inverse, not a stale value
        tdi_o = ~din[n-1];
    endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the debug access and scan-security block
// assumes das_jtag_host drives jtag; otp code only changes under reset
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import das_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic por_n = 1'b0;
    logic tck, tms, tdi, tdo;
    logic [127:0] otp = FACTORY_CODE;
    logic [3:0] tap_en;
    logic tdo_oe, returned_test_clock;
    logic [7:0] pins = 8'h3C;
    logic [7:0] cells;
    logic [3:0] tap_tdo = 4'h4;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic [31:0] addr = 32'h0000_0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic rom_sel, cpu_sel, released;
    int fail_count = 0;
    int samples_checked = 0;

    initial forever #12.5 mclk = ~mclk;

    das_top das_top_i (.mclk_i(mclk), .nrst_i(nrst),
        .power_on_reset_n_i(por_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .returned_test_clock_o(returned_test_clock),
        .otp_code_i(otp), .bscan_pins_i(pins), .bscan_cells_o(cells),
        .sec_tap_en_o(tap_en), .sec_tap_tdo_i(tap_tdo), .dbg_sel_i(sel),
        .dbg_write_i(wr), .dbg_addr_i(addr), .dbg_wdata_i(wdata),
        .dbg_rdata_o(rdata), .locator_rom_frame_select_o(rom_sel),
        .cpu_debug_frame_select_o(cpu_sel), .access_released_o(released));

    das_jtag_host das_jtag_host_i (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .tdo_i(tdo));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // the answer is registered one edge after the request is driven
    task automatic bus(input logic w, input logic [31:0] a);
        @(posedge mclk);
        sel <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= 32'hFFFF_FFFF;
        @(posedge mclk);
        sel <= 1'b0;
        wr <= 1'b0;
        #1;
    endtask

    // tck must also tick inside reset, so the tap is walked meanwhile
    task automatic do_reset(input logic por, input logic [127:0] code);
        @(posedge mclk);
        nrst <= 1'b0;
        por_n <= ~por;
        otp <= code;
        repeat (4) @(posedge mclk);
        das_jtag_host_i.to_idle();
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        @(posedge mclk);
        das_jtag_host_i.to_idle();
    endtask

    task automatic wait_rel(input logic exp);
        int n;
        n = 0;
        while (released !== exp && n < 40) begin
            @(posedge mclk);
            n++;
        end
        check("released", released, exp);
        if (released !== exp) tally_and_finish();
    endtask

    task automatic scan_word(input logic [3:0] ir, input logic [127:0] d,
                             input int n);
        logic [127:0] q;
        das_jtag_host_i.scan(1'b1, 128'(ir), IR_LEN, q);
        das_jtag_host_i.scan(1'b0, d, n, q);
        repeat (4) @(posedge mclk);
    endtask

    task automatic test_rom();
        logic [31:0] rom [5];
        rom = '{ROM_PTR_VAL, ROM_RES1_VAL, ROM_RES2_VAL, ROM_RES3_VAL,
                ROM_END_VAL};
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, ROM_FRAME_BASE + 32'(i * 4));
            check("rom word", rdata, rom[i]);
            check("rom select", rom_sel, 1'b1);
        end
        bus(1'b1, ROM_FRAME_BASE);
        bus(1'b0, ROM_FRAME_BASE);
        check("rom after write", rdata, ROM_PTR_VAL);
        bus(1'b0, ROM_FRAME_BASE + 32'h0000_0FFC);
        check("unmapped read", rdata, 32'h0000_0000);
        bus(1'b0, CPU_FRAME_BASE + 32'h0000_0FFC);
        check("cpu select", {rom_sel, cpu_sel}, 2'b01);
        bus(1'b0, CPU_FRAME_BASE + 32'h0000_1000);
        check("no select", {rom_sel, cpu_sel}, 2'b00);
    endtask

    task automatic test_open();
        logic [127:0] d;
        logic returned_test_clock_exp;
        // 37 tck falls in a 32-bit scan flip the returned clock
        returned_test_clock_exp = !returned_test_clock;
        das_jtag_host_i.scan(1'b0, 128'h0, 32, d);
        @(posedge mclk);
        check("id code", d[31:0], ID_CODE);
        check("tck return", returned_test_clock, returned_test_clock_exp);
        check("tdo enable", tdo_oe, 1'b0);
        wait_rel(1'b1);
        scan_word(IR_SELTAP, 128'hF000_0000, 32);
        check("taps open", tap_en, 4'hF);
        das_jtag_host_i.scan(1'b0, 128'hF000_0000, 32, d);
        check("tap two tdo", d[31:0], 32'hFFFF_FFFF);
        das_jtag_host_i.scan(1'b1, 128'(IR_BSCAN), IR_LEN, d);
        das_jtag_host_i.scan(1'b0, 128'h0000_00A5, 8, d);
        @(posedge mclk);
        check("bscan capture", d[7:0], pins);
        check("bscan cells", cells, 8'hA5);
    endtask

    task automatic test_lock();
        logic [127:0] code;
        logic [127:0] q;
        code = FACTORY_CODE & ~128'h1;
        do_reset(1'b1, code);
        repeat (10) @(posedge mclk);
        check("locked", released, 1'b0);
        scan_word(IR_SELTAP, 128'hF000_0000, 32);
        check("taps blocked", tap_en, 4'h0);
        das_jtag_host_i.scan(1'b1, 128'(IR_BSCAN), IR_LEN, q);
        das_jtag_host_i.scan(1'b0, 128'h0000_00A5, 8, q);
        @(posedge mclk);
        check("bscan locked", {q[7:0], cells}, 16'h0000);
        scan_word(IR_KEY, code ^ FACTORY_CODE, 128);
        wait_rel(1'b1);
        do_reset(1'b0, code);
        wait_rel(1'b1);
        do_reset(1'b1, code);
        repeat (10) @(posedge mclk);
        check("key cleared", released, 1'b0);
    endtask

    // an all-zero code must stay locked even for the matching key
    task automatic test_zero();
        do_reset(1'b1, 128'h0);
        scan_word(IR_KEY, FACTORY_CODE, 128);
        repeat (10) @(posedge mclk);
        check("zero code", released, 1'b0);
    endtask

    initial begin
        do_reset(1'b1, FACTORY_CODE);
        test_rom();
        test_open();
        test_lock();
        test_zero();
        tally_and_finish();
    end
endmodule
`default_nettype wire
